// File: dv/tb_trs_status_regs.sv
// Self-checking testbench for the temperature and reference status registers
`timescale 1ns/100ps
`default_nettype none

module tb_trs_status_regs;
  // ==========================================================
  // Signals
  logic        clk;
  logic        nrst;
  logic [5:0]  avsAddress;
  logic        avsRead;
  logic        avsWrite;
  logic [31:0] avsWritedata;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic [5:0]  evt;
  logic        refOv;
  logic        refUv;
  logic        refOvl;
  logic        refPdN;
  logic        irqOut;
  int          badCount;
  int          testsRun;

  // ==========================================================
  // Device under test
  trs_status_regs DUT (
    .clk                (clk),
    .nrst               (nrst),
    .avs_address        (avsAddress),
    .avs_read           (avsRead),
    .avs_write          (avsWrite),
    .avs_writedata      (avsWritedata),
    .avs_byteenable     (4'hf),
    .avs_readdata       (avsReaddata),
    .avs_waitrequest    (avsWaitrequest),
    .dieOvertempEvt     (evt[3]),
    .dieOvertempWarnEvt (evt[2]),
    .regOvertempEvt     (evt[1]),
    .regOvertempWarnEvt (evt[0]),
    .bgHighEvt          (evt[5]),
    .bgLowEvt           (evt[4]),
    .convRefOvervoltage (refOv),
    .convRefUndervoltage(refUv),
    .convRefOverload    (refOvl),
    .convRefPowerdownN  (refPdN),
    .irq                (irqOut)
  );

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : testDone

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One bus cycle; request held until waitrequest is sampled low
  task automatic busXfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avsAddress   <= a;
    avsWritedata <= d;
    avsRead      <= ~wr;
    avsWrite     <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avsWaitrequest === 1'b0) break;
    end
    q = avsReaddata;
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    if (n == 20) begin
      badCount++;
      $display("CHECK FAILED bus answer expected waitrequest low seen timeout");
      testDone();
    end
  endtask : busXfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask : wr

  // Read and compare in one step
  task automatic rdChk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    busXfer(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask : rdChk

  // One-cycle event pulse, then one edge for the flag to land
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 6'h00;
    @(posedge clk);
  endtask : pulse

  // ==========================================================
  // Scenarios
  task automatic testReset();
    rdChk("temp", 6'h10, 32'h0);
    rdChk("ref1", 6'h14, 32'h000000c1);
    rdChk("ref2", 6'h18, 32'hfffffff1);
    rdChk("unmapped", 6'h04, 32'h0);
    check("pdN pin", {31'h0, refPdN}, 32'h1);
    $display("test reset values done");
  endtask : testReset

  task automatic testTemp();
    logic [3:0] f;
    f = 4'h0;
    for (int i = 0; i < 4; i++) begin
      pulse(6'(1 << i));
      f[i] = 1'b1;
      rdChk("temp flags", 6'h10, {24'h0, f, 4'h0});
    end
    wr(6'h10, 32'h00000020);
    rdChk("temp one cleared", 6'h10, 32'h000000d0);
    wr(6'h10, 32'hffffffff);
    rdChk("temp all cleared", 6'h10, 32'h0);
    $display("test temperature flags done");
  endtask : testTemp

  task automatic testBandgap();
    pulse(6'h30);
    rdChk("ref1 flags", 6'h14, 32'h000000f1);
    wr(6'h14, 32'h00000010);
    rdChk("ref1 low cleared", 6'h14, 32'h000000e1);
    wr(6'h14, 32'h000008c1);
    rdChk("ref1 boot load", 6'h14, 32'h000000e1);
    wr(6'h14, 32'h00000020);
    rdChk("ref1 high cleared", 6'h14, 32'h000000c1);
    $display("test bandgap flags done");
  endtask : testBandgap

  // Event arrives in the very cycle the clearing write commits
  task automatic testSetWins();
    pulse(6'h08);
    fork
      wr(6'h10, 32'h00000080);
      begin
        @(posedge clk);
        @(posedge clk);
        evt <= 6'h08;
        @(posedge clk);
        evt <= 6'h00;
      end
    join
    rdChk("set over clear", 6'h10, 32'h00000080);
    wr(6'h10, 32'h00000080);
    $display("test set over clear done");
  endtask : testSetWins

  task automatic testRef2();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {refOv, refUv, refOvl} <= 3'(i);
      rdChk("ref2 live", 6'h18, 32'hfffffff1 | 32'(i << 1));
    end
    @(posedge clk);
    {refOv, refUv, refOvl} <= 3'b000;
    // Re-enable sequence as software must run it
    wr(6'h18, 32'h0);
    @(posedge clk);
    check("pdN low", {31'h0, refPdN}, 32'h0);
    rdChk("ref2 pd", 6'h18, 32'hfffffff0);
    wr(6'h1c, 32'h000001c0);
    wr(6'h18, 32'hffffffff);
    @(posedge clk);
    check("pdN high", {31'h0, refPdN}, 32'h1);
    $display("test reference control done");
  endtask : testRef2

  task automatic testIrq();
    wr(6'h1c, 32'h000001ff);
    rdChk("irq sts clear", 6'h1c, 32'h0);
    pulse(6'h08);
    rdChk("irq sts die", 6'h1c, 32'h00000008);
    check("irq masked", {31'h0, irqOut}, 32'h0);
    wr(6'h20, 32'h000001ff);
    repeat (2) @(posedge clk);
    check("irq raised", {31'h0, irqOut}, 32'h1);
    wr(6'h1c, 32'h00000008);
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irqOut}, 32'h0);
    refOv <= 1'b1;
    rdChk("irq sts ov", 6'h1c, 32'h00000100);
    check("irq ov", {31'h0, irqOut}, 32'h1);
    wr(6'h1c, 32'h00000100);
    refOv <= 1'b0;
    repeat (2) @(posedge clk);
    check("irq ov cleared", {31'h0, irqOut}, 32'h0);
    rdChk("temp untouched", 6'h10, 32'h00000080);
    $display("test interrupt done");
  endtask : testIrq

  // ==========================================================
  // Main sequence: 4 cycles of reset, then the scenarios
  initial begin
    badCount = 0;
    testsRun = 0;
    nrst = 1'b0;
    avsAddress = 6'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = 32'h0;
    evt = 6'h00;
    {refOv, refUv, refOvl} = 3'b000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    testReset();
    testTemp();
    testBandgap();
    testSetWins();
    testRef2();
    testIrq();
    testDone();
  end
endmodule : tb_trs_status_regs

`default_nettype wire

// File: rtl/trs_pkg.sv
// Constants and types for the temperature and reference status registers
//
// Overview of operation
// - Die overtemperature event sets temperature status bit 7; reads 1 while set.
// - Die overtemperature warning event sets temperature status bit 6; reads 1.
// - Regulator overtemperature event sets temperature status bit 5.
// - Regulator overtemperature warning event sets temperature status bit 4.
// - Software write clears the temperature flags; cleared flag reads 0.
// - Temperature status at 0x10; bits 31:8 and 3:0 read zero.
// - Boot firmware loads 0x8C1 into reference-1; hardware reset gives 0xC1. The code ignores the load and still reads 0xC1 outside bits 5:4.
// - Bandgap overvoltage trigger sets reference-1 bit 5; write clears it.
// - Bandgap undervoltage trigger sets reference-1 bit 4; write clears it.
// - Reference-1 bits 2:0 read 001, bit 3 zero, upper field reads 3.
// - Converter reference overvoltage reads 1 at reference-2 bit 3.
// - Converter reference undervoltage reads 1 at reference-2 bit 2.
// - Converter reference overload reads 1 at reference-2 bit 1.
// - Reference-2 bit 0 is read-write power-down, active low, reset 1.
// - Reference-2 reserved bits 31:4 read as ones.

package trs_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam int          TRS_AW        = 6;
  localparam logic [5:0]  TRS_OFS_TEMP  = 6'h10;
  localparam logic [5:0]  TRS_OFS_REF1  = 6'h14;
  localparam logic [5:0]  TRS_OFS_REF2  = 6'h18;
  localparam logic [5:0]  TRS_OFS_ISTS  = 6'h1c;
  localparam logic [5:0]  TRS_OFS_IMSK  = 6'h20;

  // ==========================================================
  // Field positions
  localparam int          TRS_TEMP_LSB  = 4;
  localparam int          TRS_BG_LSB    = 4;
  localparam int          TRS_REF2_LSB  = 1;
  localparam int          TRS_PD_BIT    = 0;
  localparam int          TRS_NEVT      = 9;

  // ==========================================================
  // Reset and fixed read values
  localparam logic [31:0] TRS_TEMP_RST  = 32'h00000003;
  localparam logic [31:0] TRS_REF1_FIX  = 32'h000000c1;
  localparam logic [31:0] TRS_REF1_BOOT = 32'h000008c1;
  localparam logic [31:0] TRS_REF2_RSV  = 32'hfffffff0;
  localparam logic        TRS_PD_RST    = 1'b1;
  localparam logic [8:0]  TRS_IMSK_RST  = 9'h000;

  // ==========================================================
  // Bus handshake phase
  typedef enum logic [0:0] {
    TRS_IDLE = 1'b0,
    TRS_ANS  = 1'b1
  } trs_phase_t;

  // ==========================================================
  // Whole module state
  typedef struct packed {
    trs_phase_t  phase;
    logic        waitReq;
    logic [31:0] rdata;
    logic [3:0]  tempFlags;
    logic [1:0]  bgFlags;
    logic        pdN;
    logic [2:0]  refPrev;
    logic [8:0]  irqSts;
    logic [8:0]  irqMask;
    logic        irq;
  } trs_state_t;

endpackage : trs_pkg

// File: rtl/trs_status_regs.sv
// Temperature, bandgap and converter reference status registers on Avalon-MM
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module trs_status_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dieOvertempEvt,
  input  wire logic        dieOvertempWarnEvt,
  input  wire logic        regOvertempEvt,
  input  wire logic        regOvertempWarnEvt,
  input  wire logic        bgHighEvt,
  input  wire logic        bgLowEvt,
  input  wire logic        convRefOvervoltage,
  input  wire logic        convRefUndervoltage,
  input  wire logic        convRefOverload,
  output logic             convRefPowerdownN,
  output logic             irq
);

  // ==========================================================
  // Sticky update: set has priority over clear
  function automatic logic [8:0] stickyUpd(
    input logic [8:0] cur,
    input logic [8:0] setv,
    input logic [8:0] clrv
  );
    stickyUpd = (cur & ~clrv) | setv;
  endfunction : stickyUpd

  // Address match, used by the write decode only; reads go through the case multiplexer
  function automatic logic hit(
    input logic [5:0] a,
    input logic [5:0] ofs
  );
    hit = (a == ofs);
  endfunction : hit

  // ==========================================================
  // State
  trs_pkg::trs_state_t s_r;
  trs_pkg::trs_state_t s_nxt;

  logic        req;
  logic        commit;
  logic        wrLow;
  logic [3:0]  tempEvt;
  logic [1:0]  bgEvt;
  logic [2:0]  refNow;
  logic [8:0]  evtVec;
  logic [8:0]  tempClr;
  logic [8:0]  bgClr;
  logic [8:0]  istsClr;
  logic [31:0] rdMux;
  logic [8:0]  tmpSts;

  // Bit order inside the temperature field: 7,6,5,4
  assign tempEvt = {dieOvertempEvt,
                    dieOvertempWarnEvt,
                    regOvertempEvt,
                    regOvertempWarnEvt};
  assign bgEvt   = {bgHighEvt,
                    bgLowEvt};
  assign refNow  = {convRefOvervoltage, convRefUndervoltage, convRefOverload};

  // Events for the interrupt status: level flags raise on rising edge
  assign evtVec  = {refNow & ~s_r.refPrev, bgEvt, tempEvt};

  // ==========================================================
  // Bus handshake decode
  assign req    = avs_read | avs_write;
  assign commit = req & (s_r.phase == trs_pkg::TRS_ANS);
  assign wrLow  = commit & avs_write & avs_byteenable[0];

  // Write-one-to-clear masks, byte lane 0 only, except interrupt status bit 8 on lane 1
  always_comb begin
    tempClr = '0;
    bgClr   = '0;
    istsClr = '0;
    if (wrLow && hit(avs_address, trs_pkg::TRS_OFS_TEMP)) begin
      tempClr[3:0] = avs_writedata[7:4];
    end
    if (wrLow && hit(avs_address, trs_pkg::TRS_OFS_REF1)) begin
      // A boot load carries zeros in 5:4, so it leaves the flags alone
      bgClr[1:0] = avs_writedata[5:4];
    end
    if (commit && avs_write && hit(avs_address, trs_pkg::TRS_OFS_ISTS)) begin
      istsClr[7:0] = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
      istsClr[8]   = avs_byteenable[1] & avs_writedata[8];
    end
  end

  // ==========================================================
  // Read multiplexer, unmapped reads return zero
  always_comb begin
    rdMux = '0;
    case (avs_address)
      trs_pkg::TRS_OFS_TEMP: begin
        // Only bits 7:4 carry state; the rest stay zero
        rdMux[7:4] = s_r.tempFlags;
      end
      trs_pkg::TRS_OFS_REF1: begin
        rdMux      = trs_pkg::TRS_REF1_FIX;
        rdMux[5:4] = s_r.bgFlags;
      end
      trs_pkg::TRS_OFS_REF2: begin
        rdMux      = trs_pkg::TRS_REF2_RSV;
        rdMux[3:1] = refNow;
        rdMux[0]   = s_r.pdN;
      end
      trs_pkg::TRS_OFS_ISTS: begin
        rdMux[8:0] = s_r.irqSts;
      end
      trs_pkg::TRS_OFS_IMSK: begin
        rdMux[8:0] = s_r.irqMask;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    tmpSts = '0;

    // Two-phase answer: one wait cycle, then waitrequest low once
    case (s_r.phase)
      trs_pkg::TRS_IDLE: begin
        if (req) begin
          s_nxt.phase   = trs_pkg::TRS_ANS;
          s_nxt.waitReq = 1'b0;
          s_nxt.rdata   = avs_read ? rdMux : 32'h00000000;
        end
      end
      trs_pkg::TRS_ANS: begin
        s_nxt.phase   = trs_pkg::TRS_IDLE;
        s_nxt.waitReq = 1'b1;
      end
      default: begin
        s_nxt.phase   = trs_pkg::TRS_IDLE;
        s_nxt.waitReq = 1'b1;
      end
    endcase

    // Sticky flags; hardware set beats a same-cycle clear
    tmpSts = stickyUpd({5'h00, s_r.tempFlags}, {5'h00, tempEvt}, tempClr);
    s_nxt.tempFlags = tmpSts[3:0];
    tmpSts = stickyUpd({7'h00, s_r.bgFlags}, {7'h00, bgEvt}, bgClr);
    s_nxt.bgFlags   = tmpSts[1:0];
    s_nxt.irqSts    = stickyUpd(s_r.irqSts, evtVec, istsClr);

    // Power-down control and mask; the re-enable order is up to software
    if (wrLow && hit(avs_address, trs_pkg::TRS_OFS_REF2)) begin
      s_nxt.pdN = avs_writedata[trs_pkg::TRS_PD_BIT];
    end
    if (commit && avs_write && hit(avs_address, trs_pkg::TRS_OFS_IMSK)) begin
      if (avs_byteenable[0]) begin
        s_nxt.irqMask[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        s_nxt.irqMask[8] = avs_writedata[8];
      end
    end

    s_nxt.refPrev = refNow;
    // Registered so the output is glitch free, at one cycle of latency
    s_nxt.irq     = |(s_r.irqSts & s_r.irqMask);
  end

  // ==========================================================
  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_r.phase     <= trs_pkg::TRS_IDLE;
      s_r.waitReq   <= 1'b1;
      s_r.rdata     <= '0;
      s_r.tempFlags <= trs_pkg::TRS_TEMP_RST[7:4];
      s_r.bgFlags   <= trs_pkg::TRS_REF1_FIX[5:4];
      s_r.pdN       <= trs_pkg::TRS_PD_RST;
      s_r.refPrev   <= '0;
      s_r.irqSts    <= '0;
      s_r.irqMask   <= trs_pkg::TRS_IMSK_RST;
      s_r.irq       <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign avs_readdata      = s_r.rdata;
  assign avs_waitrequest   = s_r.waitReq;
  assign convRefPowerdownN = s_r.pdN;
  assign irq               = s_r.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic       ansRd;
  logic       irqPend;
  logic [3:0] tempKill;
  assign ansRd    = avs_read & ~avs_waitrequest;
  // Pending interrupt and the temperature bits a write may drop
  assign irqPend  = |(s_r.irqSts & s_r.irqMask);
  assign tempKill = avs_writedata[7:4] & ~tempEvt;

  // Each temperature event shows in its flag one edge later
  AST_DIE_OT_SET: assert property (
    dieOvertempEvt |=> s_r.tempFlags[3])
    else $error("die overtemp flag not set");

  AST_DIE_WARN_SET: assert property (
    dieOvertempWarnEvt |=> s_r.tempFlags[2])
    else $error("die warning flag not set");

  AST_REG_OT_SET: assert property (
    regOvertempEvt |=> s_r.tempFlags[1])
    else $error("regulator overtemp flag not set");

  AST_REG_WARN_SET: assert property (
    regOvertempWarnEvt |=> s_r.tempFlags[0])
    else $error("regulator warning flag not set");

  // A one written without a new event clears the flag
  AST_TEMP_CLR: assert property (
    (wrLow && avs_address == trs_pkg::TRS_OFS_TEMP
      && avs_writedata[7] && !dieOvertempEvt)
    |=> !s_r.tempFlags[3])
    else $error("temperature flag not cleared");

  // Reserved temperature bits answer zero
  AST_TEMP_RSV: assert property (
    (ansRd && avs_address == trs_pkg::TRS_OFS_TEMP)
    |-> (avs_readdata[31:8] == 24'h000000
      && avs_readdata[3:0] == 4'h0))
    else $error("temperature reserved bits nonzero");

  // Fixed pattern of reference-1, whatever was written
  AST_REF1_FIX: assert property (
    (ansRd && avs_address == trs_pkg::TRS_OFS_REF1)
    |-> (avs_readdata[31:6] == 26'h0000003
      && avs_readdata[3:0] == 4'h1))
    else $error("reference-1 fixed bits wrong");

  AST_BG_HI_SET: assert property (
    bgHighEvt |=> s_r.bgFlags[1] && s_r.irqSts[5])
    else $error("bandgap high flag not set");

  AST_BG_LO_SET: assert property (
    bgLowEvt |=> s_r.bgFlags[0] && s_r.irqSts[4])
    else $error("bandgap low flag not set");

  // Live converter reference status, sampled at the accepting edge
  AST_REF2_STS: assert property (
    (ansRd && avs_address == trs_pkg::TRS_OFS_REF2)
    |-> avs_readdata[3:1] == $past(refNow))
    else $error("reference-2 status bits wrong");

  // Power-down bit follows a lane-0 write one edge later
  AST_PD_WRITE: assert property (
    (wrLow && avs_address == trs_pkg::TRS_OFS_REF2)
    |=> convRefPowerdownN == $past(avs_writedata[0]))
    else $error("power-down bit not written");

  AST_REF2_RSV: assert property (
    (ansRd && avs_address == trs_pkg::TRS_OFS_REF2)
    |-> avs_readdata[31:4] == 28'hfffffff)
    else $error("reference-2 reserved bits not ones");

  // Set wins over a same-cycle clearing write
  AST_SET_WINS: assert property (
    (wrLow && avs_address == trs_pkg::TRS_OFS_REF1
      && avs_writedata[5] && bgHighEvt)
    |=> s_r.bgFlags[1])
    else $error("event lost to clearing write");

  // Every request is answered within two edges
  AST_ANSWER: assert property (
    (req && avs_waitrequest) |-> ##[1:2] !avs_waitrequest)
    else $error("request not answered");

  // Interrupt follows masked status with one cycle of delay
  AST_IRQ: assert property (
    ##1 irq == $past(irqPend))
    else $error("interrupt output mismatch");

  // Reset leaves the bus idle, the reference on and no interrupt
  AST_RST_VALS: assert property (
    $rose(nrst) |-> (avs_waitrequest && convRefPowerdownN && !irq
      && s_r.tempFlags == 4'h0 && s_r.irqMask == 9'h000))
    else $error("state after reset wrong");

  // Waitrequest drops for exactly one cycle per accepted request
  AST_ONE_WAIT: assert property (
    (req && s_r.phase == trs_pkg::TRS_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest low for wrong length");

  // Read data holds while no request is on the bus
  AST_RD_HOLD: assert property (
    !req |=> $stable(avs_readdata))
    else $error("read data changed without a request");

  // A set flag stays set until a one is written to it
  AST_DIE_OT_HOLD: assert property (
    (s_r.tempFlags[3] && !(wrLow && avs_address == trs_pkg::TRS_OFS_TEMP
      && avs_writedata[7]))
    |=> s_r.tempFlags[3])
    else $error("die overtemp flag lost");

  // Every written one without an event drops its temperature flag
  AST_TEMP_CLR_ALL: assert property (
    (wrLow && avs_address == trs_pkg::TRS_OFS_TEMP)
    |=> (s_r.tempFlags & $past(tempKill)) == 4'h0)
    else $error("temperature flags not cleared");

  // Bandgap flags drop on a written one when no event is present
  AST_BG_HI_CLR: assert property (
    (wrLow && avs_address == trs_pkg::TRS_OFS_REF1
      && avs_writedata[5] && !bgHighEvt)
    |=> !s_r.bgFlags[1])
    else $error("bandgap high flag not cleared");

  AST_BG_LO_CLR: assert property (
    (wrLow && avs_address == trs_pkg::TRS_OFS_REF1
      && avs_writedata[4] && !bgLowEvt)
    |=> !s_r.bgFlags[0])
    else $error("bandgap low flag not cleared");

  // Power-down bit answers on reads as it drives the pin
  AST_PD_READ: assert property (
    (ansRd && avs_address == trs_pkg::TRS_OFS_REF2)
    |-> avs_readdata[0] == convRefPowerdownN)
    else $error("power-down read back wrong");

  // Only a lane-0 write to reference-2 moves the power-down bit
  AST_PD_HOLD: assert property (
    !(wrLow && avs_address == trs_pkg::TRS_OFS_REF2)
    |=> $stable(convRefPowerdownN))
    else $error("power-down bit moved without a write");

  // Rising reference faults latch into the interrupt status
  AST_OV_RISE: assert property (
    (convRefOvervoltage && !s_r.refPrev[2]) |=> s_r.irqSts[8])
    else $error("overvoltage rise not latched");

  AST_UV_RISE: assert property (
    (convRefUndervoltage && !s_r.refPrev[1]) |=> s_r.irqSts[7])
    else $error("undervoltage rise not latched");

  AST_OVL_RISE: assert property (
    (convRefOverload && !s_r.refPrev[0]) |=> s_r.irqSts[6])
    else $error("overload rise not latched");

  // A written one clears its interrupt status bit unless hit again
  AST_ISTS_CLR: assert property (
    (commit && avs_write && avs_address == trs_pkg::TRS_OFS_ISTS
      && avs_byteenable[0] && avs_writedata[3] && !dieOvertempEvt)
    |=> !s_r.irqSts[3])
    else $error("interrupt status not cleared");

  // A clear mask keeps the interrupt low
  AST_IRQ_MASKED: assert property (
    (s_r.irqMask == 9'h000) |=> !irq)
    else $error("interrupt raised while masked");

endmodule : trs_status_regs

`default_nettype wire
